// ---- common/rqcc_pkg.sv ----
// Types shared by the receive queue command block
package rqcc_pkg;
`include "rqcc_regs.svh"

  typedef struct packed {
    logic [15:0] data;
    logic        first;
    logic        last;
  } rqcc_rx_word_t;

  typedef struct packed {
    logic        chip_select_n;
    logic        read_strobe_n;
    logic        write_strobe_n;
    logic        cmd;
    logic [15:0] data;
  } rqcc_pins_t;

  typedef enum logic {
    RQCC_REL_IDLE  = 1'b0,
    RQCC_REL_FLUSH = 1'b1
  } rqcc_rel_state_t;

  function automatic logic rqcc_is_cmd_reg(input logic [7:0] addr);
    rqcc_is_cmd_reg = (addr[7:1] == 7'(`RQCC_ADDR_RX_QUEUE_COMMAND >> 1));
  endfunction

endpackage

// ---- common/rqcc_regs.svh ----
// Offsets, field positions, reset values and timing counts of the receive queue command block
// Operation
// RULE1: Bit 12 reports that the pending receive interrupt came from the duration threshold.
// RULE2: Bit 11 reports that the pending receive interrupt came from the byte-count threshold.
// RULE3: Bit 10 reports that the pending receive interrupt came from the frame-count threshold.
// RULE4: The three threshold status bits change only when the host writes one to interrupt bit 13.
// RULE5: Bit 9 set inserts two pad bytes ahead of each received frame; it resets to zero.
// RULE6: Bit 7 set raises the receive interrupt when the duration threshold is exceeded.
// RULE7: Bit 6 set raises the receive interrupt when the byte-count threshold is exceeded.
// RULE8: Bit 5 set raises the receive interrupt when the frame-count threshold is exceeded.
// RULE9: Bit 4 set moves the read pointer to the next frame once the current one is fully read.
// RULE10: Writing one to bit 3 opens a window where data-phase strobes reach the frame queues.
// RULE11: While the window is open, every register except this one is blocked.
// RULE12: The host writes zero to bit 3 after its transfer before touching other registers.
// RULE13: Writing one to bit 0 releases the buffer of the current bad received frame.
// RULE14: Bit 0 clears by itself once that frame memory has been released.
// RULE15: The host polls bit 0 until zero before handling another received frame.
// RULE16: Bit 3 reads as zero and writes to reserved bits are ignored.
`ifndef RQCC_REGS_SVH
`define RQCC_REGS_SVH

`define RQCC_ADDR_RX_QUEUE_COMMAND 8'h82
`define RQCC_RX_QUEUE_COMMAND_RST  16'h0000

`define RQCC_BIT_DURATION_HIT   12
`define RQCC_BIT_BYTE_COUNT_HIT 11
`define RQCC_BIT_FRAME_HIT      10
`define RQCC_BIT_IP_ALIGN       9
`define RQCC_BIT_DURATION_EN    7
`define RQCC_BIT_BYTE_COUNT_EN  6
`define RQCC_BIT_FRAME_EN       5
`define RQCC_BIT_AUTO_DEQUEUE   4
`define RQCC_BIT_DMA_WINDOW     3
`define RQCC_BIT_RELEASE        0

`define RQCC_CLK_PERIOD_NS      25
`define RQCC_DUR_TICK_NS        1000
`define RQCC_DUR_TICK_CYC       ((`RQCC_DUR_TICK_NS + `RQCC_CLK_PERIOD_NS - 1) / `RQCC_CLK_PERIOD_NS)

`define RQCC_FIFO_DEPTH         32
`define RQCC_PIN_SYNC_RST       20'hE0000

`endif

// ---- hw/rqcc_fifo.sv ----
// Valid/ready FIFO built on the small memory
`timescale 1ns/1ps
module rqcc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire logic                     in_valid,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          in_ready,
  output logic                          out_valid,
  output logic      [WIDTH-1:0]         out_data,
  input  wire logic                     out_ready,
  output logic      [$clog2(DEPTH):0]   level
);
  localparam int AW = $clog2(DEPTH);

  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] rd_ptr_d;
  logic [AW:0]   count_q;
  logic          push;
  logic          pop;

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign rd_ptr_d  = pop ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
  assign level     = count_q;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      wr_ptr_q <= push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= (AW+1)'(count_q + push - pop);
    end
  end

  rqcc_mem #(
    .WIDTH (WIDTH),
    .AW    (AW)
  ) u_mem (
    .mclk  (mclk),
    .we    (push),
    .waddr (wr_ptr_q),
    .wdata (in_data),
    .raddr (rd_ptr_d),
    .rdata (out_data)
  );
endmodule // rqcc_fifo

// ---- hw/rqcc_mem.sv ----
// Small dual-port memory with registered, write-first read data
`timescale 1ns/1ps
module rqcc_mem #(
  parameter int WIDTH = 18,
  parameter int AW    = 5
) (
  input  wire logic             mclk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_q [2**AW];

  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
  end

  // Bypass keeps a word pushed into an empty queue visible one cycle later
  always_ff @(posedge mclk)
  begin
    rdata <= (we && waddr == raddr) ? wdata : mem_q[raddr];
  end
endmodule // rqcc_mem

// ---- hw/rqcc_top.sv ----
// Receive queue command register, host pin decoder, receive buffer and threshold logic
`timescale 1ns/1ps
`include "rqcc_regs.svh"
module rqcc_top
  import rqcc_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                chip_select_n,
  input  wire logic                read_strobe_n,
  input  wire logic                write_strobe_n,
  input  wire logic                cmd,
  input  wire logic [15:0]         data_in,
  output logic      [15:0]         data_out,
  output logic                     data_oe,
  input  wire logic                rx_in_valid,
  input  wire rqcc_rx_word_t       rx_in,
  output logic                     rx_in_ready,
  output logic                     tx_out_valid,
  output logic      [15:0]         tx_out_data,
  output logic                     dequeue_next,
  input  wire logic                isr_rx_ack,
  input  wire logic [15:0]         duration_threshold_value,
  input  wire logic [15:0]         byte_count_threshold_value,
  input  wire logic [15:0]         frame_count_threshold_value,
  output logic                     rx_irq_set,
  output logic                     ext_reg_wr,
  output logic                     ext_reg_rd,
  output logic      [7:0]          ext_reg_addr,
  output logic      [15:0]         ext_reg_wdata,
  input  wire logic [15:0]         ext_reg_rdata
);
  localparam int SW = $bits(rqcc_pins_t);
  localparam logic [SW-1:0] SYNC_RST = `RQCC_PIN_SYNC_RST;
  localparam logic [5:0] TICK_LAST = 6'(`RQCC_DUR_TICK_CYC - 1);

  // Pin synchroniser and strobe edges
  rqcc_pins_t       pin_raw;
  logic [SW-1:0]    s1_q;
  logic [SW-1:0]    s2_q;
  rqcc_pins_t       pin_s;
  logic             cs3_q;
  logic             rd3_q;
  logic             wr3_q;
  logic             wr_end;
  logic             rd_start;

  assign pin_raw = '{chip_select_n, read_strobe_n, write_strobe_n, cmd, data_in};

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++)
    begin : g_sync
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          s1_q[gi] <= SYNC_RST[gi];
          s2_q[gi] <= SYNC_RST[gi];
        end
        else
        begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  assign pin_s = rqcc_pins_t'(s2_q);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cs3_q <= 1'b1;
      rd3_q <= 1'b1;
      wr3_q <= 1'b1;
    end
    else
    begin
      cs3_q <= pin_s.chip_select_n;
      rd3_q <= pin_s.read_strobe_n;
      wr3_q <= pin_s.write_strobe_n;
    end
  end

  // Write is taken when the strobe rises, read when it falls
  assign wr_end   = pin_s.write_strobe_n & ~wr3_q & ~cs3_q;
  assign rd_start = ~pin_s.read_strobe_n & rd3_q & ~pin_s.chip_select_n;

  // Command register state
  logic             align_q;
  logic [2:0]       en_q;
  logic             auto_q;
  logic             dma_q;
  logic [2:0]       sts_q;
  rqcc_rel_state_t  rel_q;
  rqcc_rel_state_t  rel_d;
  logic [7:0]       addr_q;
  logic             pend_q;
  logic [15:0]      dout_q;
  logic [15:0]      tx_q;
  logic             tx_valid_q;

  // Access routing
  logic             to_reg;
  logic             reg_hit;
  logic             wr_addr;
  logic             wr_cmd_reg;
  logic             wr_ext;
  logic             wr_tx;
  logic             rd_cmd_reg;
  logic             rd_ext;
  logic             rd_queue;
  logic             data_phase_end;
  logic [15:0]      wdata;
  logic [15:0]      cmd_word;
  logic [15:0]      rd_word;

  assign wdata          = pin_s.data;
  assign to_reg         = pend_q | ~dma_q;
  assign reg_hit        = rqcc_is_cmd_reg(addr_q);
  assign wr_addr        = wr_end & pin_s.cmd;
  assign wr_cmd_reg     = wr_end & ~pin_s.cmd & to_reg & reg_hit;
  assign wr_ext         = wr_end & ~pin_s.cmd & to_reg & ~reg_hit & ~dma_q; // RULE11
  assign wr_tx          = wr_end & ~pin_s.cmd & ~to_reg;                    // RULE10
  assign rd_cmd_reg     = rd_start & ~pin_s.cmd & to_reg & reg_hit;
  assign rd_ext         = rd_start & ~pin_s.cmd & to_reg & ~reg_hit & ~dma_q; // RULE11
  assign rd_queue       = rd_start & ~pin_s.cmd & ~to_reg;                    // RULE10
  assign data_phase_end = (wr_end | rd_start) & ~pin_s.cmd;

  assign ext_reg_wr    = wr_ext;
  assign ext_reg_rd    = rd_ext;
  assign ext_reg_addr  = addr_q;
  assign ext_reg_wdata = wdata;

  // Receive buffer
  rqcc_rx_word_t    fifo_in;
  rqcc_rx_word_t    fifo_out;
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic             fifo_out_ready;
  logic [5:0]       fifo_level;
  logic             pad_needed;
  logic             pad_done_q;
  logic             push;
  logic             pop;
  logic             host_pop;
  logic             flush_done;
  logic [5:0]       frames_q;

  assign pad_needed    = align_q & rx_in.first & ~pad_done_q; // RULE5
  assign fifo_in_valid = rx_in_valid;
  assign fifo_in       = pad_needed ? rqcc_rx_word_t'{16'h0000, 1'b1, 1'b0}
                       : rqcc_rx_word_t'{rx_in.data, rx_in.first & ~align_q, rx_in.last};
  assign rx_in_ready   = fifo_in_ready & ~pad_needed;
  assign push          = fifo_in_valid & fifo_in_ready;

  assign fifo_out_ready = rd_queue | (rel_q == RQCC_REL_FLUSH);
  assign pop            = fifo_out_ready & fifo_out_valid;
  assign host_pop       = rd_queue & fifo_out_valid;
  assign flush_done     = (rel_q == RQCC_REL_FLUSH) & fifo_out_valid & fifo_out.last;
  assign dequeue_next   = host_pop & fifo_out.last & auto_q; // RULE9

  rqcc_fifo #(
    .WIDTH ($bits(rqcc_rx_word_t)),
    .DEPTH (`RQCC_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out),
    .out_ready (fifo_out_ready),
    .level     (fifo_level)
  );

  // Thresholds
  logic [5:0]       tick_q;
  logic [15:0]      dur_q;
  logic             dur_hit;
  logic             byte_hit;
  logic             frame_hit;
  logic [2:0]       hits;
  logic             any_hit;
  logic             any_hit_q;

  assign dur_hit   = (frames_q != 6'h00) & (dur_q > duration_threshold_value);
  assign byte_hit  = {9'h000, fifo_level, 1'b0} > byte_count_threshold_value;
  assign frame_hit = {10'h000, frames_q} > frame_count_threshold_value;
  assign hits      = {dur_hit & en_q[2], byte_hit & en_q[1], frame_hit & en_q[0]};
  assign any_hit   = |hits;      // RULE6 RULE7 RULE8
  assign rx_irq_set = any_hit & ~any_hit_q;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_q    <= 6'h00;
      dur_q     <= 16'h0000;
      frames_q  <= 6'h00;
      any_hit_q <= 1'b0;
    end
    else
    begin
      // Timer runs from the first queued frame until the queue holds no frame
      tick_q    <= (frames_q == 6'h00 || tick_q == TICK_LAST) ? 6'h00 : 6'(tick_q + 1'b1);
      if (frames_q == 6'h00)
        dur_q <= 16'h0000;
      else if (tick_q == TICK_LAST && dur_q != 16'hFFFF)
        dur_q <= 16'(dur_q + 1'b1);
      frames_q  <= 6'(frames_q + (push & fifo_in.last) - (pop & fifo_out.last));
      any_hit_q <= any_hit;
    end
  end

  // Release of a bad frame: drain through its last word, then drop bit 0
  always_comb
  begin
    case (rel_q)
      RQCC_REL_IDLE:
        rel_d = (wr_cmd_reg & wdata[`RQCC_BIT_RELEASE]) ? RQCC_REL_FLUSH : RQCC_REL_IDLE; // RULE13
      RQCC_REL_FLUSH:
        rel_d = (flush_done & ~(wr_cmd_reg & wdata[`RQCC_BIT_RELEASE]))
              ? RQCC_REL_IDLE : RQCC_REL_FLUSH;                                           // RULE14
      default:
        rel_d = RQCC_REL_IDLE;
    endcase
  end

  // Register image; write-only and reserved bits read as zero
  assign cmd_word = {3'b000, sts_q, align_q, 1'b0, en_q, auto_q,
                     1'b0, 2'b00, rel_q == RQCC_REL_FLUSH};                              // RULE16

  assign rd_word = rd_cmd_reg ? cmd_word
                 : rd_ext     ? ext_reg_rdata
                 : (rd_queue & fifo_out_valid) ? fifo_out.data
                 : 16'h0000;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rel_q <= RQCC_REL_IDLE;
    end
    else
    begin
      rel_q <= rel_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      align_q <= 1'(`RQCC_RX_QUEUE_COMMAND_RST >> `RQCC_BIT_IP_ALIGN);
      en_q    <= 3'b000;
      auto_q  <= 1'b0;
      dma_q   <= 1'b0;
    end
    else if (wr_cmd_reg)
    begin
      align_q <= wdata[`RQCC_BIT_IP_ALIGN];                      // RULE5
      en_q    <= {wdata[`RQCC_BIT_DURATION_EN], wdata[`RQCC_BIT_BYTE_COUNT_EN],
                  wdata[`RQCC_BIT_FRAME_EN]};                    // RULE6 RULE7 RULE8
      auto_q  <= wdata[`RQCC_BIT_AUTO_DEQUEUE];                  // RULE9
      dma_q   <= wdata[`RQCC_BIT_DMA_WINDOW];                    // RULE10 RULE12
    end
  end

  // Status bits follow the enabled hits only on the receive interrupt acknowledge
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sts_q <= 3'b000;
    end
    else if (isr_rx_ack)
    begin
      sts_q <= hits;                                             // RULE1 RULE2 RULE3 RULE4
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pad_done_q <= 1'b0;
    end
    else if (push)
    begin
      pad_done_q <= pad_needed;                                  // RULE5
    end
  end

  // Address phase and one-shot register access inside the window
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_q <= 8'h00;
      pend_q <= 1'b0;
    end
    else if (wr_addr)
    begin
      addr_q <= wdata[7:0];
      pend_q <= 1'b1;
    end
    else if (data_phase_end)
    begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dout_q     <= 16'h0000;
      tx_q       <= 16'h0000;
      tx_valid_q <= 1'b0;
    end
    else
    begin
      if (rd_start)
        dout_q <= rd_word;
      if (wr_tx)
        tx_q <= wdata;
      tx_valid_q <= wr_tx;                                       // RULE10
    end
  end

  assign data_out     = dout_q;
  assign data_oe      = ~pin_s.chip_select_n & ~pin_s.read_strobe_n & ~rd_start;
  assign tx_out_valid = tx_valid_q;
  assign tx_out_data  = tx_q;
endmodule // rqcc_top

// ---- sim/rqcc_host.sv ----
// Host processor model driving the parallel command and data pins
`timescale 1ns/1ps
module rqcc_host (
  input  wire logic        mclk,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  output logic             chip_select_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic             cmd,
  output logic [15:0]      data_in
);
  int timeouts;

  initial
  begin
    timeouts       = 0;
    chip_select_n  = 1'b1;
    read_strobe_n  = 1'b1;
    write_strobe_n = 1'b1;
    cmd            = 1'b0;
    data_in        = 16'h5A5A;
  end

  // One strobe; a read is held until the device drives the bus
  task automatic strobe(input logic c, input logic rd, input logic [15:0] d,
                        output logic [15:0] q);
    int n;
    @(posedge mclk);
    #2;
    cmd            = c;
    data_in        = d;
    chip_select_n  = 1'b0;
    read_strobe_n  = !rd;
    write_strobe_n = rd;
    n              = 0;
    repeat (4) @(posedge mclk);
    #2;
    while (rd && data_oe !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #2;
      n++;
    end
    if (n == 20)
      timeouts++;
    q              = data_out;
    chip_select_n  = 1'b1;
    read_strobe_n  = 1'b1;
    write_strobe_n = 1'b1;
    // Data stays on the pins until the synced write edge has been taken
    repeat (4) @(posedge mclk);
    #2;
    data_in        = ~d;
    repeat (2) @(posedge mclk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    logic [15:0] q;
    strobe(1'b1, 1'b0, {8'h00, a}, q);
    strobe(1'b0, 1'b0, v, q);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] q);
    strobe(1'b1, 1'b0, {8'h00, a}, q);
    strobe(1'b0, 1'b1, 16'h0000, q);
  endtask
endmodule // rqcc_host

// ---- sim/rqcc_props.sv ----
// Concurrent checks on the command block's host pins and side outputs
`timescale 1ns/1ps
module rqcc_props (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        chip_select_n,
  input wire logic        read_strobe_n,
  input wire logic [15:0] data_out,
  input wire logic        data_oe,
  input wire logic        tx_out_valid,
  input wire logic [15:0] tx_out_data,
  input wire logic        dequeue_next,
  input wire logic        rx_irq_set,
  input wire logic        ext_reg_wr,
  input wire logic        ext_reg_rd
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Host has left the bus long enough for every synced strobe to settle
  sequence s_bus_idle;
    chip_select_n [*8];
  endsequence

  sequence s_rd_seen;
    !$past(read_strobe_n, 2) || !$past(read_strobe_n, 3) || !$past(read_strobe_n, 4);
  endsequence

  chk_oe_after_read: assert property (data_oe |-> s_rd_seen)
    else $error("data_oe high without a read strobe");
  chk_dout_holds: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("data_out changed while driven");
  chk_tx_one_pulse: assert property (tx_out_valid |=> !tx_out_valid && $stable(tx_out_data))
    else $error("tx_out_valid longer than one cycle");
  chk_tx_data_cause: assert property ($changed(tx_out_data) |-> ##[0:1] tx_out_valid)
    else $error("tx_out_data changed without a transmit pulse");
  chk_idle_no_access: assert property (s_bus_idle |-> !tx_out_valid && !ext_reg_wr && !ext_reg_rd)
    else $error("access effect with the bus idle");
  chk_ext_one_dir: assert property (ext_reg_wr |-> !ext_reg_rd ##1 !ext_reg_wr)
    else $error("ext write overlaps a read or repeats");
  chk_deq_on_read: assert property (dequeue_next |=> data_oe && !dequeue_next)
    else $error("dequeue_next outside a single host read");
  chk_irq_one_pulse: assert property (rx_irq_set |=> !rx_irq_set)
    else $error("rx_irq_set longer than one cycle");
endmodule // rqcc_props

bind rqcc_top rqcc_props u_rqcc_props (
  .mclk          (mclk),
  .reset_n       (reset_n),
  .chip_select_n (chip_select_n),
  .read_strobe_n (read_strobe_n),
  .data_out      (data_out),
  .data_oe       (data_oe),
  .tx_out_valid  (tx_out_valid),
  .tx_out_data   (tx_out_data),
  .dequeue_next  (dequeue_next),
  .rx_irq_set    (rx_irq_set),
  .ext_reg_wr    (ext_reg_wr),
  .ext_reg_rd    (ext_reg_rd)
);

// ---- sim/rx_queue_command_control_test.sv ----
// Self-checking testbench of the receive queue command block
`timescale 1ns/1ps
module rx_queue_command_control_test;
  import rqcc_pkg::*;
  logic          mclk, reset_n, rx_in_valid, isr_rx_ack, cs_n, rd_n, wr_n, cmd;
  rqcc_rx_word_t rx_in;
  logic [15:0]   data_in, data_out, tx_out_data, q, ext_wd, ext_last, dur_thr, byte_thr;
  logic          data_oe, rx_in_ready, tx_out_valid, dequeue_next, rx_irq_set, ext_reg_wr;
  logic          ext_rd;
  int            erd_cnt;
  logic [7:0]    ext_reg_addr;
  logic [15:0]   receive_frame_queue [3] = '{16'h0000, 16'h1234, 16'hBEEF};
  int            fails, check_count, tx_cnt, deq_cnt, irq_cnt, ext_cnt, n;

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  rqcc_top u_rqcc_top (
    .mclk(mclk), .reset_n(reset_n), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .cmd(cmd), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .rx_in_valid(rx_in_valid), .rx_in(rx_in), .rx_in_ready(rx_in_ready),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .dequeue_next(dequeue_next),
    .isr_rx_ack(isr_rx_ack), .duration_threshold_value(dur_thr),
    .byte_count_threshold_value(byte_thr), .frame_count_threshold_value(16'h0000),
    .rx_irq_set(rx_irq_set), .ext_reg_wr(ext_reg_wr), .ext_reg_rd(ext_rd),
    .ext_reg_addr(ext_reg_addr), .ext_reg_wdata(ext_wd), .ext_reg_rdata(16'hA5C3));

  rqcc_host u_rqcc_host (
    .mclk(mclk), .data_out(data_out), .data_oe(data_oe), .chip_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .cmd(cmd), .data_in(data_in));

  always @(posedge mclk)
  begin
    if (tx_out_valid === 1'b1) tx_cnt++;
    if (dequeue_next === 1'b1) deq_cnt++;
    if (rx_irq_set === 1'b1) irq_cnt++;
    if (ext_reg_wr === 1'b1) ext_cnt++;
    if (ext_reg_wr === 1'b1) ext_last = ext_wd;
    if (ext_rd === 1'b1) erd_cnt++;
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  task automatic push(input logic [15:0] d, input logic f, input logic l);
    int k;
    @(posedge mclk);
    #2;
    rx_in       = '{d, f, l};
    rx_in_valid = 1'b1;
    #1;
    k           = 0;
    while (rx_in_ready !== 1'b1 && k < 20)
    begin
      @(posedge mclk);
      #2;
      k++;
    end
    if (k == 20)
      fails++;
    @(posedge mclk);
    #2;
    rx_in_valid = 1'b0;
  endtask

  task automatic ack();
    @(posedge mclk);
    #2;
    isr_rx_ack = 1'b1;
    @(posedge mclk);
    #2;
    isr_rx_ack = 1'b0;
  endtask

  task automatic end_sim();
    fails += u_rqcc_host.timeouts;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #2000000;
    fails++;
    end_sim();
  end

  initial
  begin
    {fails, check_count, tx_cnt, deq_cnt, irq_cnt, ext_cnt, erd_cnt} = '0;
    dur_thr     = 16'hFFFF;
    byte_thr    = 16'hFFFF;
    reset_n     = 1'b0;
    rx_in_valid = 1'b0;
    rx_in       = '0;
    isr_rx_ack  = 1'b0;
    repeat (3) @(posedge mclk);
    #2;
    reset_n = 1'b1;
    repeat (3) @(posedge mclk);
    u_rqcc_host.rd_reg(8'h82, q);
    check("rx_queue_command", 16'h0000, q);
    $display("test reset done");
    u_rqcc_host.wr_reg(8'h82, 16'hFFFE);
    u_rqcc_host.rd_reg(8'h82, q);
    check("rx_queue_command", 16'h02F0, q);
    u_rqcc_host.wr_reg(8'h90, 16'h1111);
    u_rqcc_host.rd_reg(8'h90, q);
    check("blocked read", 16'h0000, q);
    check("ext writes", 16'h0000, 16'(ext_cnt));
    check("ext reads", 16'h0000, 16'(erd_cnt));
    u_rqcc_host.strobe(1'b0, 1'b0, 16'hC0DE, q);
    check("tx_out_data", 16'hC0DE, tx_out_data);
    check("tx pulses", 16'h0001, 16'(tx_cnt));
    $display("test window done");
    push(16'h1234, 1'b1, 1'b0);
    push(16'hBEEF, 1'b0, 1'b1);
    repeat (4) @(posedge mclk);
    check("irq pulses", 16'h0001, 16'(irq_cnt));
    u_rqcc_host.rd_reg(8'h82, q);
    check("rx_queue_command", 16'h02F0, q);
    ack();
    u_rqcc_host.rd_reg(8'h82, q);
    check("rx_queue_command", 16'h06F0, q);
    for (int i = 0; i < 3; i++)
    begin
      u_rqcc_host.strobe(1'b0, 1'b1, 16'h0000, q);
      check("queue word", receive_frame_queue[i], q);
    end
    check("dequeues", 16'h0001, 16'(deq_cnt));
    $display("test receive done");
    push(16'hAAAA, 1'b1, 1'b0);
    push(16'hBBBB, 1'b0, 1'b0);
    push(16'hCCCC, 1'b0, 1'b1);
    u_rqcc_host.wr_reg(8'h82, 16'h02F9);
    n = 0;
    q = 16'h0001;
    while (q[0] !== 1'b0 && n < 5)
    begin
      u_rqcc_host.rd_reg(8'h82, q);
      n++;
    end
    check("rx_queue_command", 16'h06F0, q);
    u_rqcc_host.strobe(1'b0, 1'b1, 16'h0000, q);
    check("released queue", 16'h0000, q);
    check("irq pulses", 16'h0002, 16'(irq_cnt));
    ack();
    u_rqcc_host.rd_reg(8'h82, q);
    check("rx_queue_command", 16'h02F0, q);
    $display("test release done");
    u_rqcc_host.wr_reg(8'h82, 16'h0000);
    u_rqcc_host.wr_reg(8'h90, 16'h1357);
    check("ext writes", 16'h0001, 16'(ext_cnt));
    check("ext_reg_addr", 16'h0090, {8'h00, ext_reg_addr});
    check("ext_reg_wdata", 16'h1357, ext_last);
    u_rqcc_host.rd_reg(8'h90, q);
    check("ext read", 16'hA5C3, q);
    check("ext reads", 16'h0001, 16'(erd_cnt));
    $display("test close done");
    u_rqcc_host.wr_reg(8'h82, 16'h00C0);
    @(posedge mclk);
    #2;
    dur_thr  = 16'h0001;
    byte_thr = 16'h0003;
    push(16'h4444, 1'b1, 1'b0);
    push(16'h5555, 1'b0, 1'b1);
    repeat (100) @(posedge mclk);
    check("irq pulses", 16'h0003, 16'(irq_cnt));
    ack();
    u_rqcc_host.rd_reg(8'h82, q);
    check("rx_queue_command", 16'h18C0, q);
    $display("test threshold done");
    end_sim();
  end
endmodule // rx_queue_command_control_test
